// *** verification/rx_source.sv ***
// partner model: receive fifo fill count and packet decoder feeding the check block
`timescale 1ns/1ps
module rx_source (
	// clock
	input wire logic mclk,
	// fifo and decoder side
	output logic [6:0] fifo_level,
	output logic packet_start,
	output rx_check_pkg::rx_field_type fields,
	output rx_check_pkg::ref_codes_type codes
);
	// reference codes start at fixed values, as the code registers would hold them
	initial begin
		fifo_level = 7'h00;
		packet_start = 1'b0;
		fields = '0;
		codes.ctrl = {8'h44, 8'h33, 8'h22, 8'h11};
		codes.ctrl5 = 8'h55;
		codes.maker = {8'hd4, 8'hc3, 8'hb2, 8'ha1};
	end
	// rewrites every reference code at once, as software reloading the code registers
	task automatic recode(input logic [7:0] x);
		@(posedge mclk);
		codes.ctrl <= {8'h44 ^ x, 8'h33 ^ x, 8'h22 ^ x, 8'h11 ^ x};
		codes.ctrl5 <= 8'h55 ^ x;
		codes.maker <= {8'hd4 ^ x, 8'hc3 ^ x, 8'hb2 ^ x, 8'ha1 ^ x};
	endtask
	// fill count moves just after a clock edge
	task automatic set_level(input logic [6:0] l);
		@(posedge mclk);
		fifo_level <= l;
	endtask
	// one packet: start, control field, maker field, one strobe cycle each
	task automatic send(input logic [7:0] c, input logic [15:0] m);
		@(posedge mclk);
		packet_start <= 1'b1;
		@(posedge mclk);
		packet_start <= 1'b0;
		fields.ctrl_valid <= 1'b1;
		fields.ctrl <= c;
		@(posedge mclk);
		// stale field data is inverted so it never looks like a held value
		fields.ctrl_valid <= 1'b0;
		fields.ctrl <= ~c;
		fields.maker_valid <= 1'b1;
		fields.maker <= m;
		@(posedge mclk);
		fields.maker_valid <= 1'b0;
		fields.maker <= ~m;
	endtask
endmodule

// *** verification/test_rx_check.sv ***
// self-checking testbench of the receive level and field check block
`timescale 1ns/1ps
module test_rx_check;
	// clock, reset and apb
	logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [rx_check_pkg::ADDR_W-1:0] paddr;
	logic [rx_check_pkg::DATA_W-1:0] pwdata, prdata;
	// partner side, events and results
	logic [6:0] fifo_level;
	logic packet_start;
	rx_check_pkg::rx_field_type fields;
	rx_check_pkg::ref_codes_type codes;
	logic sync_detect, rx_sync_established, cont_timer_expire;
	logic irq, rx_abort, rx_continue, rx_stop;
	// bookkeeping
	int mismatches = 0;
	int comparisons = 0;
	int abort_n = 0;
	int cont_n = 0;
	int stop_n = 0;
	rx_check rx_check_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fifo_level(fifo_level), .packet_start(packet_start),
		.fields(fields), .codes(codes), .sync_detect(sync_detect),
		.rx_sync_established(rx_sync_established), .cont_timer_expire(cont_timer_expire),
		.irq(irq), .rx_abort(rx_abort), .rx_continue(rx_continue), .rx_stop(rx_stop));
	rx_source rx_source_inst (.mclk(mclk), .fifo_level(fifo_level),
		.packet_start(packet_start), .fields(fields), .codes(codes));
	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// count one-cycle result pulses so none is missed
	always @(posedge mclk) begin
		if (rx_abort === 1'b1) abort_n <= abort_n + 1;
		if (rx_continue === 1'b1) cont_n <= cont_n + 1;
		if (rx_stop === 1'b1) stop_n <= stop_n + 1;
	end
	// verdict and end of run
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// compare seen against expected
	task check(input string n, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask
	// one apb transfer; holds the request until pready is sampled high
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			$display("BAD pready expected 1 seen 0");
			complete_run();
		end
	endtask
	// register write
	task wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, i, d, r, e);
	endtask
	// register read compared with expected data and error flag
	task rd(input logic [7:0] i, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, i, 32'h0000_0000, r, e);
		check("read data", r, x);
		check("pslverr", {31'h0, e}, {31'h0, xe});
	endtask
	// let events settle, read interrupt status, then clear it all
	task st(input logic [31:0] x);
		repeat (3) @(posedge mclk);
		rd(rx_check_pkg::IDX_IRQ_STATUS, x, 1'b0);
		wr(rx_check_pkg::IDX_IRQ_STATUS, 32'h0000_ffff);
	endtask
	// one-cycle event pulse: 0 sync word, 1 rx sync, else timer expiry
	task ev(input int k);
		@(posedge mclk);
		case (k)
			0: sync_detect <= 1'b1;
			1: rx_sync_established <= 1'b1;
			default: cont_timer_expire <= 1'b1;
		endcase
		@(posedge mclk);
		sync_detect <= 1'b0;
		rx_sync_established <= 1'b0;
		cont_timer_expire <= 1'b0;
	endtask
	// one packet through the field check with given path and config
	task fc(input logic [1:0] p, input logic [7:0] cc, mc, c, input logic [15:0] m,
		input logic [31:0] xs, input int xa);
		int a0;
		wr(rx_check_pkg::IDX_PATH_SEL, {30'h0, p});
		wr(rx_check_pkg::IDX_CTRL_CFG, {24'h0, cc});
		wr(rx_check_pkg::IDX_MAKER_CFG, {24'h0, mc});
		a0 = abort_n;
		rx_source_inst.send(c, m);
		st(xs);
		check("aborts", 32'(abort_n - a0), 32'(xa));
	endtask
	// reset values and an unmapped place
	task t_reset;
		rd(rx_check_pkg::IDX_FULL_CFG, 32'h0000_0000, 1'b0);
		rd(rx_check_pkg::IDX_EMPTY_CFG, 32'h0000_0000, 1'b0);
		rd(rx_check_pkg::IDX_CTRL_CFG, 32'h0000_0000, 1'b0);
		rd(rx_check_pkg::IDX_MAKER_CFG, 32'h0000_0000, 1'b0);
		rd(rx_check_pkg::IDX_PATH_SEL, 32'h0000_0000, 1'b0);
		rd(8'h20, 32'h0000_0000, 1'b1);
		rd(rx_check_pkg::IDX_MONITOR, 32'h0000_0000, 1'b0);
		$display("test reset done");
	endtask
	// full level crossing, masking, clearing and disable
	task t_full;
		wr(rx_check_pkg::IDX_IRQ_MASK, 32'h0000_ffff);
		rd(rx_check_pkg::IDX_IRQ_MASK, 32'h0000_4030, 1'b0);
		wr(rx_check_pkg::IDX_FULL_CFG, 32'h0000_008a);
		rx_source_inst.set_level(7'd10);
		st(32'h0000_0000);
		rx_source_inst.set_level(7'd11);
		repeat (3) @(posedge mclk);
		check("irq", {31'h0, irq}, 32'h0000_0001);
		wr(rx_check_pkg::IDX_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge mclk);
		check("irq", {31'h0, irq}, 32'h0000_0000);
		wr(rx_check_pkg::IDX_IRQ_MASK, 32'h0000_4030);
		st(32'h0000_0020);
		repeat (2) @(posedge mclk);
		check("irq", {31'h0, irq}, 32'h0000_0000);
		wr(rx_check_pkg::IDX_FULL_CFG, 32'h0000_000a);
		rd(rx_check_pkg::IDX_FULL_CFG, 32'h0000_000a, 1'b0);
		rx_source_inst.set_level(7'd0);
		rx_source_inst.set_level(7'd40);
		st(32'h0000_0000);
		$display("test full level done");
	endtask
	// empty level crossing and disable
	task t_empty;
		wr(rx_check_pkg::IDX_FULL_CFG, 32'h0000_0000);
		rx_source_inst.set_level(7'd5);
		wr(rx_check_pkg::IDX_EMPTY_CFG, 32'h0000_0082);
		rx_source_inst.set_level(7'd2);
		st(32'h0000_0000);
		rx_source_inst.set_level(7'd1);
		st(32'h0000_0010);
		wr(rx_check_pkg::IDX_EMPTY_CFG, 32'h0000_0002);
		rx_source_inst.set_level(7'd5);
		rx_source_inst.set_level(7'd0);
		st(32'h0000_0000);
		$display("test empty level done");
	endtask
	// control field codes, polarity and abort
	task t_field;
		fc(2'h0, 8'h02, 8'h00, 8'h22, 16'h0000, 32'h0000_4000, 0);
		fc(2'h0, 8'h02, 8'h00, 8'h11, 16'h0000, 32'h0000_0000, 0);
		fc(2'h0, 8'hc1, 8'h00, 8'h22, 16'h0000, 32'h0000_4000, 1);
		fc(2'h0, 8'hc1, 8'h00, 8'h11, 16'h0000, 32'h0000_0000, 0);
		$display("test control field done");
	endtask
	// pattern five and maker codes
	task t_pat5_maker;
		fc(2'h0, 8'hd0, 8'h01, 8'h55, 16'h0000, 32'h0000_4000, 0);
		fc(2'h0, 8'hc0, 8'h05, 8'h00, 16'hc3a1, 32'h0000_0000, 0);
		fc(2'h0, 8'hc0, 8'h05, 8'h00, 16'hc3a2, 32'h0000_4000, 1);
		fc(2'h0, 8'hc0, 8'h0a, 8'h00, 16'hd4b2, 32'h0000_0000, 0);
		$display("test pattern and maker done");
	endtask
	// rewritten reference codes are the ones compared
	task t_recode;
		rx_source_inst.recode(8'hff);
		fc(2'h0, 8'hd8, 8'h00, 8'haa, 16'h0000, 32'h0000_4000, 0);
		fc(2'h0, 8'hc8, 8'h0f, 8'hbb, 16'h3c4d, 32'h0000_0000, 0);
		fc(2'h0, 8'hc8, 8'h0f, 8'hbb, 16'h4d3c, 32'h0000_4000, 1);
		rx_source_inst.recode(8'h00);
		$display("test recoded references done");
	endtask
	// field check only in data path modes 00 and 11
	task t_path;
		fc(2'h1, 8'hc1, 8'h00, 8'h22, 16'h0000, 32'h0000_0000, 0);
		fc(2'h2, 8'hc1, 8'h00, 8'h22, 16'h0000, 32'h0000_0000, 0);
		fc(2'h3, 8'hc1, 8'h00, 8'h22, 16'h0000, 32'h0000_4000, 1);
		$display("test data path done");
	endtask
	// every continuation selector code after a flushing expiry
	task t_cont;
		int c0, s0;
		for (int s = 0; s < 4; s++) begin
			wr(rx_check_pkg::IDX_PATH_SEL, 32'h0000_0000);
			wr(rx_check_pkg::IDX_MAKER_CFG, 32'(s) << 4);
			ev(2);
			repeat (2) @(posedge mclk);
			c0 = cont_n;
			s0 = stop_n;
			case (s)
				1: fc(2'h0, 8'h02, 8'(s << 4), 8'h22, 16'h0000, 32'h0000_4000, 0);
				2: ev(1);
				default: ev(0);
			endcase
			rd(rx_check_pkg::IDX_MONITOR, (s == 3) ? 32'h0000_0100 : (32'h0000_0100 << s), 1'b0);
			ev(2);
			repeat (2) @(posedge mclk);
			check("continue", 32'(cont_n - c0), (s < 3) ? 32'h1 : 32'h0);
			check("stop", 32'(stop_n - s0), (s == 3) ? 32'h1 : 32'h0);
		end
		$display("test continuation done");
	endtask
	// main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		sys_rst = 1'b1;
		sync_detect = 1'b0;
		rx_sync_established = 1'b0;
		cont_timer_expire = 1'b0;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_full();
		t_empty();
		t_field();
		t_pat5_maker();
		t_recode();
		t_path();
		t_cont();
		complete_run();
	end
endmodule

// *** verilog/code_match.sv ***
// compares one value against a set of individually enabled reference codes
`timescale 1ns/1ps
module code_match #(
	parameter int N = 4,
	parameter int W = 8
) (
	// reference set
	input wire logic [N-1:0][W-1:0] codes,
	input wire logic [N-1:0] enable,
	// value under test
	input wire logic [W-1:0] value,
	// result
	output logic any_en,
	output logic hit
);
	// per code equality, gated by its enable
	logic [N-1:0] eq;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_cmp
			// a disabled code never contributes
			assign eq[i] = enable[i] && (codes[i] == value);
		end
	endgenerate

	// field is checked only when some code is enabled
	assign any_en = |enable;
	assign hit = |eq;
endmodule

// *** verilog/rx_check.sv ***
// receive fifo level notification and packet field check with apb registers
//
// Contract
// - fill above full level raises bit 5
// - full level acts only when enabled
// - fill below empty level raises bit 4
// - empty level acts only when enabled
// - mismatch aborts packet only when abort set
// - check interrupt on match or mismatch by polarity
// - four enables choose compared control codes
// - pattern five hit interrupts, skips later checks
// - four enables choose compared maker codes
// - selector picks event continuing reception on expiry
// - field check only in path modes 00, 11
`timescale 1ns/1ps
module rx_check (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rx_check_pkg::ADDR_W-1:0] paddr,
	input wire logic [rx_check_pkg::DATA_W-1:0] pwdata,
	output logic [rx_check_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive fifo fill level, 0 to 64 bytes
	input wire logic [6:0] fifo_level,
	// packet decoder side
	input wire logic packet_start,
	input wire rx_check_pkg::rx_field_type fields,
	input wire rx_check_pkg::ref_codes_type codes,
	// reception events and continuous operation timer
	input wire logic sync_detect,
	input wire logic rx_sync_established,
	input wire logic cont_timer_expire,
	// results
	output logic irq,
	output logic rx_abort,
	output logic rx_continue,
	output logic rx_stop
);
	// configuration registers
	logic [7:0] full_cfg_q;
	logic [7:0] empty_cfg_q;
	logic [7:0] ctrl_cfg_q;
	logic [7:0] maker_cfg_q;
	logic [1:0] path_sel_q;
	// interrupt registers
	logic [15:0] irq_status_q;
	logic [15:0] irq_status_d;
	logic [15:0] irq_mask_q;
	logic [15:0] irq_set;
	logic [15:0] irq_clr;
	// bus output flops
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	// result pulses
	logic rx_abort_q;
	logic rx_continue_q;
	logic rx_stop_q;
	// level crossing detection
	logic full_cond;
	logic empty_cond;
	logic full_prev_q;
	logic empty_prev_q;
	logic full_ev;
	logic empty_ev;
	// field check sequencer
	rx_check_pkg::check_state_type state_q;
	rx_check_pkg::check_state_type state_d;
	logic mode_ok;
	logic match_ev;
	logic mism_ev;
	logic pat5_ev;
	logic check_ev;
	logic ctrl_any;
	logic ctrl_hit;
	logic mk1_any;
	logic mk1_hit;
	logic mk2_any;
	logic mk2_hit;
	// continuation event memory: sync, check, rx sync
	logic [2:0] seen_q;
	logic [2:0] seen_ev;
	logic [1:0] cont_sel;
	// decoded access
	logic [7:0] idx;
	logic in_range;
	logic setup;
	logic wr;
	logic [7:0] wbyte;
	logic [31:0] rd_val;
	logic rd_err;

	// field views
	assign cont_sel = maker_cfg_q[rx_check_pkg::CONT_SEL_LSB +: 2];
	assign idx = paddr[9:2];
	assign in_range = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
	assign setup = psel && !penable;
	assign wr = psel && penable && pready_q && pwrite;
	assign wbyte = pwdata[7:0];

	// outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign rx_abort = rx_abort_q;
	assign rx_continue = rx_continue_q;
	assign rx_stop = rx_stop_q;

	// read decode, evaluated in the setup phase
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (!in_range) begin
			rd_err = 1'b1;
		end else if (idx == rx_check_pkg::IDX_FULL_CFG) begin
			rd_val[7:0] = full_cfg_q;
		end else if (idx == rx_check_pkg::IDX_EMPTY_CFG) begin
			rd_val[7:0] = empty_cfg_q;
		end else if (idx == rx_check_pkg::IDX_CTRL_CFG) begin
			rd_val[7:0] = ctrl_cfg_q;
		end else if (idx == rx_check_pkg::IDX_MAKER_CFG) begin
			rd_val[7:0] = maker_cfg_q;
		end else if (idx == rx_check_pkg::IDX_IRQ_STATUS) begin
			rd_val[15:0] = irq_status_q;
		end else if (idx == rx_check_pkg::IDX_IRQ_MASK) begin
			rd_val[15:0] = irq_mask_q;
		end else if (idx == rx_check_pkg::IDX_PATH_SEL) begin
			rd_val[1:0] = path_sel_q;
		end else if (idx == rx_check_pkg::IDX_MONITOR) begin
			// live fill level, busy flag and pending continuation events
			rd_val[6:0] = fifo_level;
			rd_val[7] = (state_q != rx_check_pkg::CHK_IDLE);
			rd_val[10:8] = seen_q;
		end else begin
			// unmapped word
			rd_err = 1'b1;
		end
	end

	// apb answer: one access cycle, data and error captured at setup
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
				pslverr_q <= rd_err;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// configuration writes take effect at the completing edge
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			full_cfg_q <= rx_check_pkg::CFG_RST;
			empty_cfg_q <= rx_check_pkg::CFG_RST;
			ctrl_cfg_q <= rx_check_pkg::CFG_RST;
			maker_cfg_q <= rx_check_pkg::CFG_RST;
			path_sel_q <= rx_check_pkg::PATH_RST;
			irq_mask_q <= rx_check_pkg::IRQ_RST;
		end else if (wr && in_range) begin
			if (idx == rx_check_pkg::IDX_FULL_CFG) begin
				full_cfg_q <= wbyte;
			end else if (idx == rx_check_pkg::IDX_EMPTY_CFG) begin
				empty_cfg_q <= wbyte;
			end else if (idx == rx_check_pkg::IDX_CTRL_CFG) begin
				ctrl_cfg_q <= wbyte;
			end else if (idx == rx_check_pkg::IDX_MAKER_CFG) begin
				maker_cfg_q <= wbyte;
			end else if (idx == rx_check_pkg::IDX_PATH_SEL) begin
				path_sel_q <= wbyte[1:0];
			end else if (idx == rx_check_pkg::IDX_IRQ_MASK) begin
				// only implemented vector bits are kept
				irq_mask_q <= pwdata[15:0] & rx_check_pkg::IRQ_IMPL;
			end
		end
	end

	// level conditions; a cleared enable suppresses the notification
	assign full_cond = full_cfg_q[rx_check_pkg::LEVEL_EN_BIT]
		&& (fifo_level > {1'b0, full_cfg_q[rx_check_pkg::LEVEL_MSB:0]});
	assign empty_cond = empty_cfg_q[rx_check_pkg::LEVEL_EN_BIT]
		&& (fifo_level < {1'b0, empty_cfg_q[rx_check_pkg::LEVEL_MSB:0]});
	// events fire on the crossing, not while the level stays past it
	assign full_ev = full_cond && !full_prev_q;
	assign empty_ev = empty_cond && !empty_prev_q;

	// crossing history
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			full_prev_q <= 1'b0;
			empty_prev_q <= 1'b0;
		end else begin
			full_prev_q <= full_cond;
			empty_prev_q <= empty_cond;
		end
	end

	// reference code comparators
	code_match #(.N(4), .W(8)) u_ctrl_match (
		.codes(codes.ctrl),
		.enable(ctrl_cfg_q[3:0]),
		.value(fields.ctrl),
		.any_en(ctrl_any),
		.hit(ctrl_hit)
	);
	// maker codes 1 and 2 check the first byte
	code_match #(.N(2), .W(8)) u_maker1_match (
		.codes(codes.maker[1:0]),
		.enable(maker_cfg_q[1:0]),
		.value(fields.maker[7:0]),
		.any_en(mk1_any),
		.hit(mk1_hit)
	);
	// maker codes 3 and 4 check the second byte
	code_match #(.N(2), .W(8)) u_maker2_match (
		.codes(codes.maker[3:2]),
		.enable(maker_cfg_q[3:2]),
		.value(fields.maker[15:8]),
		.any_en(mk2_any),
		.hit(mk2_hit)
	);

	// only the fifo length mode and data output mode 2 check fields
	assign mode_ok = (path_sel_q == rx_check_pkg::PATH_FIFO)
		|| (path_sel_q == rx_check_pkg::PATH_DOUT2);

	// field check sequencer next state and events
	always_comb begin
		state_d = state_q;
		match_ev = 1'b0;
		mism_ev = 1'b0;
		pat5_ev = 1'b0;
		if (packet_start) begin
			state_d = mode_ok ? rx_check_pkg::CHK_CTRL : rx_check_pkg::CHK_IDLE;
		end else begin
			case (state_q)
				rx_check_pkg::CHK_CTRL: begin
					if (fields.ctrl_valid) begin
						if (ctrl_cfg_q[rx_check_pkg::PAT5_BIT]
							&& (fields.ctrl == codes.ctrl5)) begin
							// special pattern ends the checks with no mismatch
							pat5_ev = 1'b1;
							state_d = rx_check_pkg::CHK_IDLE;
						end else if (ctrl_any && !ctrl_hit) begin
							mism_ev = 1'b1;
							state_d = rx_check_pkg::CHK_IDLE;
						end else begin
							state_d = rx_check_pkg::CHK_MAKER;
						end
					end
				end
				rx_check_pkg::CHK_MAKER: begin
					if (fields.maker_valid) begin
						// a byte with no enabled code is not checked
						if ((mk1_any && !mk1_hit) || (mk2_any && !mk2_hit)) begin
							mism_ev = 1'b1;
						end else begin
							match_ev = 1'b1;
						end
						state_d = rx_check_pkg::CHK_IDLE;
					end
				end
				default: begin
					state_d = rx_check_pkg::CHK_IDLE;
				end
			endcase
		end
	end

	// check interrupt follows the polarity bit; pattern five always raises it
	assign check_ev = pat5_ev
		|| (ctrl_cfg_q[rx_check_pkg::POL_BIT] ? mism_ev : match_ev);

	// sequencer state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= rx_check_pkg::CHK_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// abort pulse on mismatch when discarding is selected
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_abort_q <= 1'b0;
		end else begin
			rx_abort_q <= mism_ev && ctrl_cfg_q[rx_check_pkg::ABORT_BIT];
		end
	end

	// interrupt vector: events set, write one clears, set wins
	always_comb begin
		irq_set = 16'h0000;
		irq_set[rx_check_pkg::IRQ_FULL_BIT] = full_ev;
		irq_set[rx_check_pkg::IRQ_EMPTY_BIT] = empty_ev;
		irq_set[rx_check_pkg::IRQ_CHECK_BIT] = check_ev;
		irq_clr = 16'h0000;
		if (wr && in_range && (idx == rx_check_pkg::IDX_IRQ_STATUS)) begin
			irq_clr = pwdata[15:0];
		end
		irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
	end

	// status register and gated level interrupt
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_status_q <= rx_check_pkg::IRQ_RST;
			irq_q <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	// events that may let reception continue
	assign seen_ev = {rx_sync_established, check_ev, sync_detect};

	// event memory, emptied at each expiry; a same-cycle event survives
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			seen_q <= 3'h0;
		end else begin
			seen_q <= (cont_timer_expire ? 3'h0 : seen_q) | seen_ev;
		end
	end

	// continue or stop decision at timer expiry; reserved code stops
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_continue_q <= 1'b0;
			rx_stop_q <= 1'b0;
		end else begin
			rx_continue_q <= 1'b0;
			rx_stop_q <= 1'b0;
			if (cont_timer_expire) begin
				case (cont_sel)
					rx_check_pkg::CONT_SYNC: begin
						rx_continue_q <= seen_q[0] | seen_ev[0];
						rx_stop_q <= !(seen_q[0] | seen_ev[0]);
					end
					rx_check_pkg::CONT_CHECK: begin
						rx_continue_q <= seen_q[1] | seen_ev[1];
						rx_stop_q <= !(seen_q[1] | seen_ev[1]);
					end
					rx_check_pkg::CONT_RXSYNC: begin
						rx_continue_q <= seen_q[2] | seen_ev[2];
						rx_stop_q <= !(seen_q[2] | seen_ev[2]);
					end
					default: begin
						rx_stop_q <= 1'b1;
					end
				endcase
			end
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// a checked control field that passes leads to the maker stage
	sequence s_ctrl_pass;
		state_q == rx_check_pkg::CHK_CTRL && fields.ctrl_valid && !packet_start
		&& !pat5_ev && !mism_ev;
	endsequence
	// a maker field arriving in the maker stage
	sequence s_maker_seen;
		state_q == rx_check_pkg::CHK_MAKER && fields.maker_valid && !packet_start;
	endsequence

	property p_full_sets;
		full_ev |=> irq_status_q[rx_check_pkg::IRQ_FULL_BIT] ##1 irq_mask_q[5] |-> irq_q;
	endproperty
	a_full_sets: assert property (p_full_sets) else $error("full crossing lost");

	property p_full_gate;
		!full_cfg_q[rx_check_pkg::LEVEL_EN_BIT] ##1 !full_cfg_q[rx_check_pkg::LEVEL_EN_BIT]
		|-> !$rose(full_prev_q);
	endproperty
	a_full_gate: assert property (p_full_gate) else $error("full level acted disabled");

	property p_empty_sets;
		empty_ev |=> irq_status_q[rx_check_pkg::IRQ_EMPTY_BIT];
	endproperty
	a_empty_sets: assert property (p_empty_sets) else $error("empty crossing lost");

	property p_empty_gate;
		!empty_cfg_q[rx_check_pkg::LEVEL_EN_BIT] |=> !empty_prev_q;
	endproperty
	a_empty_gate: assert property (p_empty_gate) else $error("empty level acted disabled");

	property p_abort;
		mism_ev && ctrl_cfg_q[rx_check_pkg::ABORT_BIT] |=> rx_abort_q ##1 !rx_abort_q;
	endproperty
	a_abort: assert property (p_abort) else $error("abort pulse wrong");

	property p_no_abort;
		!(mism_ev && ctrl_cfg_q[rx_check_pkg::ABORT_BIT]) |=> !rx_abort_q;
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("abort without mismatch");

	property p_polarity;
		(match_ev && !ctrl_cfg_q[rx_check_pkg::POL_BIT])
		|| (mism_ev && ctrl_cfg_q[rx_check_pkg::POL_BIT])
		|=> irq_status_q[rx_check_pkg::IRQ_CHECK_BIT];
	endproperty
	a_polarity: assert property (p_polarity) else $error("check interrupt missing");

	property p_ctrl_to_maker;
		s_ctrl_pass |=> state_q == rx_check_pkg::CHK_MAKER;
	endproperty
	a_ctrl_to_maker: assert property (p_ctrl_to_maker) else $error("maker stage skipped");

	property p_pat5;
		pat5_ev |-> !mism_ev ##1 (state_q == rx_check_pkg::CHK_IDLE
			&& irq_status_q[rx_check_pkg::IRQ_CHECK_BIT]);
	endproperty
	a_pat5: assert property (p_pat5) else $error("pattern five handling wrong");

	property p_maker_free;
		s_maker_seen ##0 (maker_cfg_q[3:0] == 4'h0) |-> match_ev ##1
			state_q == rx_check_pkg::CHK_IDLE;
	endproperty
	a_maker_free: assert property (p_maker_free) else $error("unchecked maker failed");

	property p_reserved_stop;
		cont_timer_expire && cont_sel == 2'h3 |=> rx_stop_q && !rx_continue_q;
	endproperty
	a_reserved_stop: assert property (p_reserved_stop) else $error("reserved select continued");

	property p_mode_gate;
		packet_start && !mode_ok |=> state_q == rx_check_pkg::CHK_IDLE;
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("check ran in wrong path mode");

	property p_set_wins;
		check_ev && irq_clr[rx_check_pkg::IRQ_CHECK_BIT]
		|=> irq_status_q[rx_check_pkg::IRQ_CHECK_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a set");
endmodule

// *** verilog/rx_check_pkg.sv ***
// constants, types and register map of the receive level and field check block
package rx_check_pkg;
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FULL_CFG = 8'h19;
	localparam logic [7:0] IDX_EMPTY_CFG = 8'h1a;
	localparam logic [7:0] IDX_CTRL_CFG = 8'h1b;
	localparam logic [7:0] IDX_MAKER_CFG = 8'h1c;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
	localparam logic [7:0] IDX_PATH_SEL = 8'h32;
	localparam logic [7:0] IDX_MONITOR = 8'h33;
	// reset values
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] IRQ_RST = 16'h0000;
	localparam logic [1:0] PATH_RST = 2'h0;
	// level register fields
	localparam int LEVEL_EN_BIT = 7;
	localparam int LEVEL_MSB = 5;
	// control check register fields
	localparam int ABORT_BIT = 7;
	localparam int POL_BIT = 6;
	localparam int PAT5_BIT = 4;
	// maker check register fields
	localparam int CONT_SEL_LSB = 4;
	// interrupt vector positions
	localparam int IRQ_W = 16;
	localparam int IRQ_EMPTY_BIT = 4;
	localparam int IRQ_FULL_BIT = 5;
	localparam int IRQ_CHECK_BIT = 14;
	localparam logic [15:0] IRQ_IMPL = 16'h4030;
	// receive data path codes that allow field checking
	localparam logic [1:0] PATH_FIFO = 2'h0;
	localparam logic [1:0] PATH_DOUT2 = 2'h3;
	// continuation selector codes
	localparam logic [1:0] CONT_SYNC = 2'h0;
	localparam logic [1:0] CONT_CHECK = 2'h1;
	localparam logic [1:0] CONT_RXSYNC = 2'h2;
	// field check sequencer
	typedef enum logic [1:0] {
		CHK_IDLE,
		CHK_CTRL,
		CHK_MAKER
	} check_state_type;
	// reference codes supplied by the code registers outside
	typedef struct packed {
		logic [3:0][7:0] ctrl;
		logic [7:0] ctrl5;
		logic [3:0][7:0] maker;
	} ref_codes_type;
	// received fields from the packet decoder
	typedef struct packed {
		logic ctrl_valid;
		logic [7:0] ctrl;
		logic maker_valid;
		logic [15:0] maker;
	} rx_field_type;
endpackage
